// file: hw/irq_flag_pkg.sv
/*
 * constants and carrier types for the interrupt flag output and timer gate block.
 * assumes a single 100 MHz clock and an ahb-lite master with word accesses.
 */
package irq_flag_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PRR = 8'h00;
    localparam logic [7:0] OFS_PER = 8'h04;
    localparam logic [7:0] OFS_IFL = 8'h08;
    localparam logic [7:0] OFS_MKL = 8'h0c;
    localparam logic [7:0] OFS_IFH = 8'h10;
    localparam logic [7:0] OFS_MKH = 8'h14;
    localparam logic [7:0] OFS_FE = 8'h18;
    localparam logic [7:0] OFS_FOCTL = 8'h1c;
    localparam logic [7:0] OFS_EVT_STAT = 8'h20;
    localparam logic [7:0] OFS_EVT_CLR = 8'h24;
    localparam logic [7:0] OFS_EVT_EN = 8'h28;
    localparam logic [7:0] OFS_OUT_CLR = 8'h2c;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_TMR_RESET = 0;
    localparam int BIT_TMR_CLOCK = 0;
    localparam int BIT_TMR_END = 5;
    localparam int BIT_FO = 0;
    localparam int BIT_CMP0_FE = 6;
    localparam int BIT_FO_EN = 2;
    localparam int BIT_FO_INV = 1;
    localparam int BIT_FO_MODE = 0;
    // event status bits
    localparam int EVT_TMR_END = 0;
    localparam int EVT_FO = 1;
    localparam int EVT_W = 2;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PRR = 8'h01;
    localparam logic [7:0] RST_PER = 8'h00;
    localparam logic [7:0] RST_IF = 8'h00;
    localparam logic [7:0] RST_MKL = 8'hff;
    localparam logic [7:0] RST_MKH = 8'hff;
    localparam logic [7:0] MKH_FIXED = 8'hfe;
    localparam logic [7:0] RST_FE = 8'h00;
    localparam logic [7:0] RST_FOCTL = 8'h00;
    localparam logic [7:0] FOCTL_MASK = 8'h07;
    localparam logic [15:0] TMR_PERIOD_RST = 16'hffff;
    // ------------------------------------------------------------
    // ahb-lite codes
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic [7:0] prr;
        logic [7:0] per;
        logic [7:0] ifl;
        logic [7:0] mkl;
        logic ifh;
        logic mkh;
        logic [7:0] fe;
        logic [2:0] foctl;
        logic [EVT_W-1:0] evt_stat;
        logic [EVT_W-1:0] evt_en;
        logic fo_latch;
    } regs_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
    } ahb_req_t;
endpackage

// file: hw/irq_flag_output.sv
/*
 * interrupt flag, mask and flag-status output logic with timer reset and clock gate,
 * plus a free-running 16-bit timer whose wrap is the timer end event.
 * assumes one clock domain; comparator and other sources arrive as pulses on core_clk_i.
 */
// Contract
// - the timer is held reset while the timer reset bit is 1 and runs when it is 0.
// - the timer clock is stopped when the clock-supply bit is 0 and delivered when 1.
// - the timer end flag at bit 5 reads 1 once a request was generated, else 0.
// - software writes to a flag register can clear pending flags.
// - timer end mask bit 0 enables servicing, 1 disables it.
// - the flag-output flag at bit 0 reads 1 while pending, other bits read 0.
// - flag-output mask bit 0 enables servicing when 0, other mask bits read 1.
// - the flag-change enable register holds one enable bit for each of eight sources.
// - comparator 0 may change its flag only while its enable bit 6 is 1.
// - with output enable bit 2 set the flag status drives the flag output, else disabled.
// - output polarity bit 1 selects positive logic at 0 and inverted logic at 1.
// - with clear-mode 0 the output follows the request and software cannot clear it.
// - with clear-mode 1 the output stays set until software clears it.
`timescale 1ns/10ps
module irq_flag_output
    import irq_flag_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [7:0] src_req_i,
    output logic [7:0] srv_req_o,
    output logic timer_tick_o,
    output logic [15:0] timer_count_o,
    output logic flag_status_output_o,
    output logic flag_status_output_oe_n_o,
    output logic irq_o
);
    import irq_flag_pkg::*;

    // ------------------------------------------------------------
    // source pulses from logic on the same clock
    // ------------------------------------------------------------
    // src_req_i: 0 ad, 1 itv, 2 itv ch0, 3 itv ch1, 4 timer (ignored, internal),
    // 5 converter, 6 cmp0, 7 cmp1 -- same order as flag_change_enable
    logic [7:0] src_req;

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    ahb_req_t req;
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic take;
    logic rd_take;
    logic wr_take;
    logic wr_now;
    logic [7:0] wdat;

    always_comb
    begin
        req.hsel = hsel_i;
        req.haddr = haddr_i;
        req.htrans = htrans_i;
        req.hwrite = hwrite_i;
        req.hsize = hsize_i;
        req.hready = hready_i;
    end

    assign take = req.hsel && req.hready && req.htrans == HTRANS_NONSEQ;
    assign rd_take = take && !req.hwrite;
    assign wr_take = take && req.hwrite;
    assign wr_now = wr_pend_r;
    assign wdat = hwdata_i[7:0];

    // ------------------------------------------------------------
    // timer
    // ------------------------------------------------------------
    logic [15:0] tmr_r, tmr_nxt;
    logic tmr_hold;
    logic tmr_run;
    logic tmr_wrap;
    regs_t r, n;

    assign tmr_hold = r.prr[BIT_TMR_RESET];
    assign tmr_run = !tmr_hold && r.per[BIT_TMR_CLOCK];
    assign tmr_wrap = tmr_run && tmr_r == TMR_PERIOD_RST;

    always_comb
    begin
        tmr_nxt = tmr_r;
        if (tmr_hold)
        begin
            tmr_nxt = 16'h0000;
        end
        else if (tmr_run)
        begin
            tmr_nxt = tmr_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tmr_r <= 16'h0000;
        end
        else
        begin
            tmr_r <= tmr_nxt;
        end
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] set_l;
    logic set_h;
    logic fo_req;
    logic [EVT_W-1:0] evt_set;
    logic sw_out_clr;
    logic wr_prr;
    logic wr_per;
    logic wr_ifl;
    logic wr_mkl;
    logic wr_ifh;
    logic wr_mkh;
    logic wr_fe;
    logic wr_foctl;
    logic wr_evt_clr;
    logic wr_evt_en;
    logic wr_out_clr;

    // ------------------------------------------------------------
    // data phase write strobes
    // ------------------------------------------------------------
    assign wr_prr = wr_now && wr_addr_r == OFS_PRR;
    assign wr_per = wr_now && wr_addr_r == OFS_PER;
    assign wr_ifl = wr_now && wr_addr_r == OFS_IFL;
    assign wr_mkl = wr_now && wr_addr_r == OFS_MKL;
    assign wr_ifh = wr_now && wr_addr_r == OFS_IFH;
    assign wr_mkh = wr_now && wr_addr_r == OFS_MKH;
    assign wr_fe = wr_now && wr_addr_r == OFS_FE;
    assign wr_foctl = wr_now && wr_addr_r == OFS_FOCTL;
    assign wr_evt_clr = wr_now && wr_addr_r == OFS_EVT_CLR;
    assign wr_evt_en = wr_now && wr_addr_r == OFS_EVT_EN;
    assign wr_out_clr = wr_now && wr_addr_r == OFS_OUT_CLR;

    always_comb
    begin
        src_req = src_req_i;
        src_req[BIT_TMR_END - 1] = tmr_wrap;
    end

    // ------------------------------------------------------------
    // flag set sources
    // ------------------------------------------------------------
    always_comb
    begin
        // flag bits map: ad and others live elsewhere; irq_flags_2_low layout
        set_l = 8'h00;
        set_l[BIT_TMR_END] = tmr_wrap && r.fe[4];
        set_l[4] = src_req[3] && r.fe[3];
        set_l[3] = src_req[2] && r.fe[2];
        set_l[2] = src_req[5] && r.fe[5];
        set_l[1] = src_req[7] && r.fe[7];
        set_l[0] = src_req[BIT_CMP0_FE] && r.fe[BIT_CMP0_FE];
        // combined flag status: any enabled source request
        fo_req = |(src_req & r.fe);
        set_h = fo_req;
        sw_out_clr = wr_out_clr && wdat[BIT_FO];
        evt_set = '0;
        evt_set[EVT_TMR_END] = set_l[BIT_TMR_END];
        evt_set[EVT_FO] = set_h;
    end

    always_comb
    begin
        n = r;
        if (wr_prr)
        begin
            n.prr = wdat & 8'h01;
        end
        if (wr_per)
        begin
            n.per = wdat & 8'h01;
        end
        if (wr_ifl)
        begin
            n.ifl = r.ifl & wdat;
        end
        if (wr_mkl)
        begin
            n.mkl = wdat;
        end
        if (wr_ifh)
        begin
            n.ifh = r.ifh & wdat[BIT_FO];
        end
        if (wr_mkh)
        begin
            n.mkh = wdat[BIT_FO];
        end
        if (wr_fe)
        begin
            n.fe = wdat;
        end
        if (wr_foctl)
        begin
            n.foctl = wdat[2:0];
        end
        if (wr_evt_clr)
        begin
            n.evt_stat = r.evt_stat & ~wdat[EVT_W-1:0];
        end
        if (wr_evt_en)
        begin
            n.evt_en = wdat[EVT_W-1:0];
        end
        // set wins over clear; flags hold regardless of mask
        n.ifl = n.ifl | set_l;
        n.ifh = n.ifh | set_h;
        n.evt_stat = n.evt_stat | evt_set;
        // software clear mode latch
        if (sw_out_clr)
        begin
            n.fo_latch = 1'b0;
        end
        if (fo_req)
        begin
            n.fo_latch = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            r.prr <= RST_PRR;
            r.per <= RST_PER;
            r.ifl <= RST_IF;
            r.mkl <= RST_MKL;
            r.ifh <= 1'b0;
            r.mkh <= 1'b1;
            r.fe <= RST_FE;
            r.foctl <= 3'h0;
            r.evt_stat <= '0;
            r.evt_en <= '0;
            r.fo_latch <= 1'b0;
        end
        else
        begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // service requests and interrupt line
    // ------------------------------------------------------------
    logic [7:0] srv_r, srv_nxt;
    logic irq_r, irq_nxt;

    always_comb
    begin
        srv_nxt = 8'h00;
        srv_nxt[BIT_TMR_END] = n.ifl[BIT_TMR_END] & ~n.mkl[BIT_TMR_END];
        srv_nxt[BIT_FO] = n.ifh & ~n.mkh;
        irq_nxt = |(n.evt_stat & n.evt_en);
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            srv_r <= 8'h00;
            irq_r <= 1'b0;
        end
        else
        begin
            srv_r <= srv_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // bus data phase
    // ------------------------------------------------------------
    always_comb
    begin
        wr_pend_nxt = wr_take;
        wr_addr_nxt = take ? req.haddr[7:0] : wr_addr_r;
        rdata_nxt = rdata_r;
        // next values, so a read right behind a write sees that write
        if (rd_take)
        begin
            unique case (req.haddr[7:0])
                OFS_PRR: rdata_nxt = {24'h0, n.prr};
                OFS_PER: rdata_nxt = {24'h0, n.per};
                OFS_IFL: rdata_nxt = {24'h0, n.ifl};
                OFS_MKL: rdata_nxt = {24'h0, n.mkl};
                OFS_IFH: rdata_nxt = {31'h0, n.ifh};
                OFS_MKH: rdata_nxt = {24'h0, MKH_FIXED | {7'h0, n.mkh}};
                OFS_FE: rdata_nxt = {24'h0, n.fe};
                OFS_FOCTL: rdata_nxt = {29'h0, n.foctl};
                OFS_EVT_STAT: rdata_nxt = {30'h0, n.evt_stat};
                OFS_EVT_EN: rdata_nxt = {30'h0, n.evt_en};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // flag-status output and interrupt
    // ------------------------------------------------------------
    logic fo_r, fo_nxt;
    logic fo_oen_r, fo_oen_nxt;
    logic fo_level;

    always_comb
    begin
        // hardware clear mode follows the request, software mode uses the latch
        fo_level = r.foctl[BIT_FO_MODE] ? n.fo_latch : fo_req;
        fo_nxt = r.foctl[BIT_FO_EN] ? (fo_level ^ r.foctl[BIT_FO_INV]) : 1'b0;
        fo_oen_nxt = !r.foctl[BIT_FO_EN];
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            fo_r <= 1'b0;
            fo_oen_r <= 1'b1;
        end
        else
        begin
            fo_r <= fo_nxt;
            fo_oen_r <= fo_oen_nxt;
        end
    end

    assign hrdata_o = rdata_r;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign srv_req_o = srv_r;
    assign timer_tick_o = tmr_wrap;
    assign timer_count_o = tmr_r;
    assign flag_status_output_o = fo_r;
    assign flag_status_output_oe_n_o = fo_oen_r;
    assign irq_o = irq_r;
endmodule // irq_flag_output

// file: tb/irq_flag_output_assertions.sv
/* port checker for irq_flag_output.
   assumes one clock, word writes with data in bits 7:0, bound below. */
`timescale 1ns/10ps
module irq_flag_output_assertions
    import irq_flag_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [7:0] src_req_i,
    input wire logic [7:0] srv_req_o,
    input wire logic timer_tick_o,
    input wire logic [15:0] timer_count_o,
    input wire logic flag_status_output_o,
    input wire logic flag_status_output_oe_n_o,
    input wire logic irq_o
);
    logic wr_q, hold_r, gate_r, en_r, inv_r, mode_r;
    logic [7:0] ad_q;
    logic [7:0] fe_r;
    wire logic take = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
    // ------------------------------------------------------------
    // shadow of written control bits
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_q <= 1'b0;
            ad_q <= 8'h00;
            hold_r <= RST_PRR[0];
            gate_r <= RST_PER[0];
            fe_r <= RST_FE;
            {en_r, inv_r, mode_r} <= RST_FOCTL[2:0];
        end
        else
        begin
            wr_q <= take && hwrite_i;
            ad_q <= haddr_i[7:0];
            if (wr_q && ad_q == OFS_PRR)
                hold_r <= hwdata_i[0];
            if (wr_q && ad_q == OFS_PER)
                gate_r <= hwdata_i[0];
            if (wr_q && ad_q == OFS_FE)
                fe_r <= hwdata_i[7:0];
            if (wr_q && ad_q == OFS_FOCTL)
                {en_r, inv_r, mode_r} <= hwdata_i[2:0];
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    a_bus_ok: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready or not okay");
    a_srv_unused_zero: assert property (srv_req_o[4:1] == 4'h0 && srv_req_o[7:6] == 2'h0)
        else $error("unused service request bit set");
    a_oe_follows_en: assert property ($stable(en_r) |-> flag_status_output_oe_n_o == !en_r)
        else $error("output enable disagrees with enable bit");
    a_timer_hold_zero: assert property (hold_r |=> timer_count_o == 16'h0000 && !timer_tick_o)
        else $error("timer moved while held");
    a_gate_freezes: assert property (!gate_r && !hold_r |=> $stable(timer_count_o))
        else $error("timer moved without clock");
    a_pin_hw_follow: assert property (en_r && !mode_r && !fe_r[4] |=>
        flag_status_output_o == $past(|(src_req_i & fe_r) ^ inv_r))
        else $error("pin does not follow request");
    a_pin_sw_holds: assert property (en_r && mode_r && !wr_q && !$past(wr_q)
        && flag_status_output_o != inv_r |=> flag_status_output_o != inv_r)
        else $error("latched pin cleared without software");
    a_mkh_fixed_ones: assert property (take && !hwrite_i && haddr_i[7:0] == OFS_MKH
        |=> hrdata_o[7:1] == 7'h7f)
        else $error("mask high fixed bits not one");
    a_ifh_upper_zero: assert property (take && !hwrite_i && haddr_i[7:0] == OFS_IFH
        |=> hrdata_o[31:1] == 31'h0)
        else $error("flag high upper bits not zero");
    c_irq: cover property ($rose(irq_o));
    c_tick: cover property (timer_tick_o);
    c_sw_latched: cover property (en_r && mode_r && flag_status_output_o != inv_r);
endmodule // irq_flag_output_assertions

bind irq_flag_output irq_flag_output_assertions chk (.core_clk_i, .rstn_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .src_req_i,
    .srv_req_o, .timer_tick_o, .timer_count_o, .flag_status_output_o,
    .flag_status_output_oe_n_o, .irq_o);

// file: tb/tb.sv
/* self-checking bench for irq_flag_output.
   drives ahb-lite and source pulses itself; the checker is bound to uut. */
`timescale 1ns/10ps
module tb;
    import irq_flag_pkg::*;
    logic core_clk_i, rstn_i, hsel_i, hwrite_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic [7:0] src_req_i, srv_req_o, f, s;
    logic [15:0] timer_count_o, t;
    logic hreadyout_o, hresp_o, timer_tick_o, flag_status_output_o, flag_status_output_oe_n_o;
    logic irq_o;
    logic [31:0] d;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int i;
    int seed = 32'h5eb1dde0;

    irq_flag_output uut (.core_clk_i, .rstn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hready_i(hreadyout_o), .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o,
        .src_req_i, .srv_req_o, .timer_tick_o, .timer_count_o, .flag_status_output_o,
        .flag_status_output_oe_n_o, .irq_o);

    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    function logic exp_fo(input logic [7:0] sv, input logic [7:0] fv);
        return |(sv & fv & 8'hef);
    endfunction

    task summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        htrans_i <= HTRANS_NONSEQ;
        hwrite_i <= w;
        @(posedge core_clk_i);
        while (hreadyout_o !== 1'b1) @(posedge core_clk_i);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= v;
        @(posedge core_clk_i);
        while (hreadyout_o !== 1'b1) @(posedge core_clk_i);
        d = hrdata_o;
    endtask

    task wrw(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
        repeat (2) @(posedge core_clk_i);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(d, e);
    endtask

    task pulse(input logic [7:0] sv);
        src_req_i <= sv;
        @(posedge core_clk_i);
        src_req_i <= 8'h00;
        @(posedge core_clk_i);
    endtask

    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            errors++;
            summarize();
        end
    end

    initial
    begin
        rstn_i = 1'b0;
        hsel_i = 1'b0;
        haddr_i = 32'h0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hsize_i = HSIZE_WORD;
        hwdata_i = 32'h0;
        src_req_i = 8'h00;
        repeat (8) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        @(posedge core_clk_i);
        rdc(OFS_PRR, 32'h1);
        rdc(OFS_PER, 32'h0);
        rdc(OFS_IFL, 32'h0);
        rdc(OFS_IFH, 32'h0);
        rdc(OFS_MKH, 32'hff);
        rdc(8'h30, 32'h0);
        wrw(OFS_MKH, 32'h0);
        rdc(OFS_MKH, 32'hfe);
        $display("test reset and masks done");
        for (i = 0; i < 8; i++)
        begin
            f = (i == 0) ? 8'hbf : (i == 1) ? 8'h40 : 8'($random(seed));
            s = (i < 2) ? 8'h40 : 8'($random(seed));
            wrw(OFS_FE, {24'h0, f});
            rdc(OFS_FE, {24'h0, f});
            pulse(s);
            rdc(OFS_IFH, {31'h0, exp_fo(s, f)});
            chk({24'h0, srv_req_o}, {31'h0, exp_fo(s, f)});
            wrw(OFS_MKH, 32'h1);
            rdc(OFS_IFH, {31'h0, exp_fo(s, f)});
            wrw(OFS_MKH, 32'h0);
            wrw(OFS_IFH, 32'h0);
            rdc(OFS_IFH, 32'h0);
        end
        wrw(OFS_MKH, 32'h1);
        $display("test flag change enable done");
        wrw(OFS_FE, 32'h40);
        for (i = 0; i < 4; i++)
        begin
            wrw(OFS_FOCTL, 32'(4 + i));
            chk({31'h0, flag_status_output_oe_n_o}, 32'h0);
            pulse(8'h40);
            repeat (3) @(posedge core_clk_i);
            chk({31'h0, flag_status_output_o}, 32'(i[1] ^ i[0]));
            wrw(OFS_OUT_CLR, 32'h1);
            chk({31'h0, flag_status_output_o}, 32'(i[1]));
            wrw(OFS_IFH, 32'h0);
        end
        wrw(OFS_FOCTL, 32'h0);
        chk({31'h0, flag_status_output_oe_n_o}, 32'h1);
        $display("test flag output done");
        wrw(OFS_FE, 32'h10);
        wrw(OFS_IFL, 32'h0);
        wrw(OFS_EVT_EN, 32'h1);
        wrw(OFS_PRR, 32'h0);
        wrw(OFS_PER, 32'h1);
        while (timer_tick_o !== 1'b1) @(posedge core_clk_i);
        repeat (2) @(posedge core_clk_i);
        rdc(OFS_IFL, 32'h20);
        chk({24'h0, srv_req_o}, 32'h0);
        wrw(OFS_MKL, 32'hdf);
        chk({24'h0, srv_req_o}, 32'h20);
        chk({31'h0, irq_o}, 32'h1);
        wrw(OFS_EVT_EN, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        wrw(OFS_EVT_EN, 32'h1);
        wrw(OFS_EVT_CLR, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        wrw(OFS_IFL, 32'h0);
        rdc(OFS_IFL, 32'h0);
        wrw(OFS_PER, 32'h0);
        t = timer_count_o;
        repeat (20) @(posedge core_clk_i);
        chk({16'h0, timer_count_o}, {16'h0, t});
        wrw(OFS_PRR, 32'h1);
        chk({15'h0, timer_tick_o, timer_count_o}, 32'h0);
        $display("test timer and interrupt done");
        summarize();
    end
endmodule // tb
